// [pkg/boot_loader_pkg.sv]
// Shared constants for the boot flash and boot UART loader
package boot_loader_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SPI_MAX_HZ = 25_000_000;
  localparam int SYNC_HALF_MIN = 3;
  localparam int SCK_HALF_RATE = (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
  localparam int SCK_HALF_CYC = (SCK_HALF_RATE > SYNC_HALF_MIN) ? SCK_HALF_RATE : SYNC_HALF_MIN;
  localparam int UART_BAUD = 115200;
  localparam int UART_DATA_BITS = 8;
  localparam int UART_FRAME_BITS = UART_DATA_BITS + 2;
  localparam int UART_MIN_DIV = 8;
  localparam int STRAP_WAIT = 2;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_DATA = 8'h03;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] CMD_READ_ID = 8'h9f;
  localparam logic [7:0] DUMMY_OUT = 8'hff;
  localparam int ADDR_BYTES = 3;
  localparam int ID_BYTES = 3;
  localparam int LEN_BYTES = 3;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 4096;
  localparam int PAGE_AW = $clog2(PAGE_BYTES);
  localparam int SECTOR_AW = $clog2(SECTOR_BYTES);
  localparam int STATUS_WIP_BIT = 0;
  localparam int NET_ADDR_COUNT = 3;
  localparam int NET_ADDR_BYTES = 6;
  localparam logic BOOT_SEL_FLASH = 1'b0;
  localparam logic BOOT_SEL_UART = 1'b1;
  typedef logic [1:0] section_t;
  localparam section_t SEC_NET_ADDR = 2'h0;
  localparam section_t SEC_CONFIG = 2'h1;
  localparam section_t SEC_FIRMWARE = 2'h2;
endpackage

// [pkg/boot_uart_if.sv]
// Byte crossing between the loader core and the boot UART link domain
`timescale 1ns/1ps
interface boot_uart_if;
  logic rx_toggle;
  logic [7:0] rx_byte;
  logic tx_toggle;
  logic [7:0] tx_byte;
  logic tx_done_toggle;
  modport core (input rx_toggle, input rx_byte, input tx_done_toggle, output tx_toggle, output tx_byte);
  modport link (output rx_toggle, output rx_byte, output tx_done_toggle, input tx_toggle, input tx_byte);
endinterface

// [hdl/boot_uart_link.sv]
// Fixed-format boot UART running in the link clock domain
`timescale 1ns/1ps
module boot_uart_link
  import boot_loader_pkg::*;
#(
  parameter int UART_CLK_HZ = 6_250_000
) (
  input wire logic uart_clk,
  input wire logic rst_b,
  input wire logic rx_line,
  output logic tx_line,
  boot_uart_if.link lk
);
  localparam int BAUD_DIV = (UART_CLK_HZ + UART_BAUD / 2) / UART_BAUD;
  localparam int BW = $clog2(BAUD_DIV) + 1;
  localparam logic [BW-1:0] DIV_LAST = BW'(BAUD_DIV - 1);
  localparam logic [BW-1:0] DIV_HALF = BW'(BAUD_DIV / 2 - 1);

  generate
    if (BAUD_DIV < UART_MIN_DIV) begin : g_chk
      $error("boot_uart_link: link clock too slow for the baud rate");
    end
  endgenerate

  typedef enum logic [1:0] {rx_idle, rx_start, rx_bits, rx_stop} rx_state_e;
  rx_state_e rx_state_reg;
  logic rx_m_reg, rx_s_reg;
  logic [BW-1:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg, rx_byte_reg;
  logic rx_tog_reg;
  logic tx_t1_reg, tx_t2_reg, tx_t3_reg;
  logic tx_busy_reg;
  logic [UART_FRAME_BITS-1:0] tx_sh_reg;
  logic [3:0] tx_bit_reg;
  logic [BW-1:0] tx_cnt_reg;
  logic tx_line_reg, tx_done_reg;

  wire rx_tick = (rx_cnt_reg == DIV_LAST);
  wire rx_half = (rx_cnt_reg == DIV_HALF);
  wire tx_tick = (tx_cnt_reg == DIV_LAST);
  wire tx_evt = tx_t2_reg ^ tx_t3_reg;

  assign lk.rx_toggle = rx_tog_reg;
  assign lk.rx_byte = rx_byte_reg;
  assign lk.tx_done_toggle = tx_done_reg;
  assign tx_line = tx_line_reg;

  // Receive: 8 data bits LSB first, one stop bit, no parity
  always_ff @(posedge uart_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_m_reg <= 1'b1;
      rx_s_reg <= 1'b1;
      rx_state_reg <= rx_idle;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_byte_reg <= '0;
      rx_tog_reg <= 1'b0;
    end else begin
      rx_m_reg <= rx_line;
      rx_s_reg <= rx_m_reg;
      rx_cnt_reg <= (rx_state_reg == rx_idle || rx_tick) ? '0 : rx_cnt_reg + 1'b1;
      unique case (rx_state_reg)
        rx_idle: if (!rx_s_reg) rx_state_reg <= rx_start;
        rx_start: if (rx_half) begin
          rx_cnt_reg <= '0;
          rx_bit_reg <= '0;
          rx_state_reg <= rx_s_reg ? rx_idle : rx_bits;
        end
        rx_bits: if (rx_tick) begin
          rx_sh_reg <= {rx_s_reg, rx_sh_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 1'b1;
          if (rx_bit_reg == 3'(UART_DATA_BITS - 1)) rx_state_reg <= rx_stop;
        end
        rx_stop: if (rx_tick) begin
          if (rx_s_reg) begin
            rx_byte_reg <= rx_sh_reg;
            rx_tog_reg <= ~rx_tog_reg;
          end
          rx_state_reg <= rx_idle;
        end
      endcase
    end
  end

  // Transmit: start bit, 8 data bits LSB first, stop bit
  always_ff @(posedge uart_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_t1_reg <= 1'b0;
      tx_t2_reg <= 1'b0;
      tx_t3_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= '1;
      tx_bit_reg <= '0;
      tx_cnt_reg <= '0;
      tx_line_reg <= 1'b1;
      tx_done_reg <= 1'b0;
    end else begin
      tx_t1_reg <= lk.tx_toggle;
      tx_t2_reg <= tx_t1_reg;
      tx_t3_reg <= tx_t2_reg;
      if (!tx_busy_reg) begin
        if (tx_evt) begin
          tx_busy_reg <= 1'b1;
          tx_sh_reg <= {1'b1, lk.tx_byte, 1'b0};
          tx_bit_reg <= '0;
          tx_cnt_reg <= '0;
        end
      end else begin
        tx_line_reg <= tx_sh_reg[0];
        tx_cnt_reg <= tx_tick ? '0 : tx_cnt_reg + 1'b1;
        if (tx_tick) begin
          tx_sh_reg <= {1'b1, tx_sh_reg[UART_FRAME_BITS-1:1]};
          tx_bit_reg <= tx_bit_reg + 1'b1;
          if (tx_bit_reg == 4'(UART_FRAME_BITS - 1)) begin
            tx_busy_reg <= 1'b0;
            tx_done_reg <= ~tx_done_reg;
          end
        end
      end
    end
  end
endmodule

// [hdl/boot_flash_uart_loader.sv]
// Boot loader core: strap, serial flash master, UART firmware load and output buffer
//
// Contract
// - Strap 0 boots from serial flash; strap 1 loads firmware over the boot UART.
// - Boot UART fixed at 115200 baud, 8 data bits, 1 stop, no parity, no flow control.
// - Boot UART has only a transmit line and a receive line.
// - UART load rewrites flash without reading the stored image first.
// - Flash serial clock never exceeds 25 MHz.
// - Flash words are eight bits, most significant bit first, plain SPI framing.
// - Flash serial clock rests high whenever no transfer runs.
// - Sample flash data on rising clock edges, change output on falling edges.
// - Drive active-low select, clock and data out; receive on a separate data input.
// - Write enable, write disable and chip erase are single opcode bytes.
// - Status read returns one byte; identification read returns three bytes.
// - Read data and page program send opcode plus three address bytes, then data.
// - Sector erase opcode plus three address bytes erases one 4 Kbyte sector.
// - Flash boot fetches network addresses, configuration and firmware from flash.
`timescale 1ns/1ps
module boot_flash_uart_loader
  import boot_loader_pkg::*;
#(
  parameter int IMAGE_BYTES = 65536,
  parameter int CONFIG_BYTES = 256,
  parameter int UART_CLK_HZ = 6_250_000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic uart_clk,
  input wire logic boot_select,
  input wire logic boot_serial_rx_line,
  output logic boot_serial_tx_line,
  output logic flash_cs_b,
  output logic flash_serial_clock,
  output logic flash_data_out,
  input wire logic flash_data_in,
  output logic [7:0] image_data,
  output section_t image_section,
  output logic image_valid,
  input wire logic image_ready,
  output logic [23:0] flash_id,
  output logic flash_boot_mode,
  output logic boot_done,
  output logic uart_overrun
);
  localparam int NET_BYTES = NET_ADDR_COUNT * NET_ADDR_BYTES;
  localparam logic [23:0] IMAGE_LAST = 24'(IMAGE_BYTES - 1);
  localparam logic [23:0] NET_END = 24'(NET_BYTES);
  localparam logic [23:0] CFG_END = 24'(NET_BYTES + CONFIG_BYTES);
  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);

  generate
    if (IMAGE_BYTES <= NET_BYTES + CONFIG_BYTES || IMAGE_BYTES > (1 << 24) || SCK_HALF_CYC > 16) begin : g_chk
      $error("boot_flash_uart_loader: image size or clock rate cannot be served");
    end
  endgenerate

  typedef enum logic [4:0] {
    st_strap, st_id_cmd, st_id_data, st_rd_cmd, st_rd_data, st_boot_done,
    st_len, st_wait_rx, st_wren, st_erase, st_pp_hdr, st_pp_data,
    st_poll_cmd, st_poll_data, st_echo, st_load_done, st_gap
  } seq_state_e;

  seq_state_e state_reg, nxt_reg, ret_reg;
  logic sel_m_reg, sel_s_reg;
  logic [1:0] strap_cnt_reg;
  logic mode_reg;
  logic miso_m_reg, miso_s_reg;
  logic rxt1_reg, rxt2_reg, rxt3_reg;
  logic txd1_reg, txd2_reg, txd3_reg;
  logic rx_pend_reg, overrun_reg;
  logic sck_reg, mosi_reg, cs_b_reg;
  logic busy_reg, done_reg;
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic [3:0] half_reg, gap_reg;
  logic sent_reg, echo_sent_reg;
  logic [1:0] idx_reg;
  logic [23:0] cnt_reg, addr_reg, remain_reg, id_reg;
  logic [7:0] data_reg;
  logic erased_reg, pp_open_reg;
  logic tx_tog_reg;
  logic [7:0] tx_byte_reg;
  logic head_v_reg, tail_v_reg;
  logic [9:0] head_reg, tail_reg;

  boot_uart_if uart_bus ();

  boot_uart_link #(
    .UART_CLK_HZ(UART_CLK_HZ)
  ) u_link (
    .uart_clk(uart_clk),
    .rst_b(rst_b),
    .rx_line(boot_serial_rx_line),
    .tx_line(boot_serial_tx_line),
    .lk(uart_bus.link)
  );

  assign uart_bus.tx_toggle = tx_tog_reg;
  assign uart_bus.tx_byte = tx_byte_reg;

  // Event detection on synchronised toggles
  wire rx_evt = rxt2_reg ^ rxt3_reg;
  wire tx_done_evt = txd2_reg ^ txd3_reg;
  wire [7:0] rx_data = uart_bus.rx_byte;

  // Byte engine handshake
  wire half_end = (half_reg == HALF_LAST);
  wire eng_done = done_reg;
  wire [7:0] eng_rx = sh_reg;
  wire buf_full = tail_v_reg;
  wire sending = (state_reg == st_id_cmd) || (state_reg == st_id_data) || (state_reg == st_rd_cmd) ||
                 (state_reg == st_rd_data) || (state_reg == st_wren) || (state_reg == st_erase) ||
                 (state_reg == st_pp_hdr) || (state_reg == st_pp_data) || (state_reg == st_poll_cmd) ||
                 (state_reg == st_poll_data) || (state_reg == st_load_done);
  wire eng_go = sending && !sent_reg && !busy_reg && !done_reg && !(state_reg == st_rd_data && buf_full);
  wire last_hdr = (idx_reg == 2'(ADDR_BYTES));
  wire [7:0] addr_byte = (idx_reg == 2'h1) ? addr_reg[23:16] : (idx_reg == 2'h2) ? addr_reg[15:8] : addr_reg[7:0];
  wire [7:0] hdr_op = (state_reg == st_erase) ? SECTOR_ERASE_CMD :
                      (state_reg == st_pp_hdr) ? CMD_PAGE_PROGRAM : CMD_READ_DATA;
  wire [7:0] tx_sel = (state_reg == st_id_cmd) ? CMD_READ_ID :
                      (state_reg == st_wren) ? CMD_WRITE_ENABLE :
                      (state_reg == st_poll_cmd) ? CMD_READ_STATUS :
                      (state_reg == st_load_done) ? CMD_WRITE_DISABLE :
                      (state_reg == st_pp_data) ? data_reg :
                      (state_reg == st_rd_cmd || state_reg == st_erase || state_reg == st_pp_hdr) ?
                      ((idx_reg == 2'h0) ? hdr_op : addr_byte) : DUMMY_OUT;
  wire page_last = &addr_reg[PAGE_AW-1:0];
  wire sector_last = &addr_reg[SECTOR_AW-1:0];
  wire sector_start = (addr_reg[SECTOR_AW-1:0] == '0);
  wire rx_take = rx_pend_reg && ((state_reg == st_len) || (state_reg == st_wait_rx && remain_reg != '0));
  wire [1:0] sec_sel = (cnt_reg < NET_END) ? SEC_NET_ADDR : (cnt_reg < CFG_END) ? SEC_CONFIG : SEC_FIRMWARE;
  wire buf_push = eng_done && (state_reg == st_rd_data);
  wire buf_pop = head_v_reg && image_ready;

  assign flash_cs_b = cs_b_reg;
  assign flash_serial_clock = sck_reg;
  assign flash_data_out = mosi_reg;
  assign image_data = head_reg[7:0];
  assign image_section = head_reg[9:8];
  assign image_valid = head_v_reg;
  assign flash_id = id_reg;
  assign flash_boot_mode = (mode_reg == BOOT_SEL_FLASH);
  assign boot_done = (state_reg == st_boot_done);
  assign uart_overrun = overrun_reg;

  // Synchronisers for pins and cross-domain toggles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {sel_m_reg, sel_s_reg, miso_m_reg, miso_s_reg} <= 4'h0;
      {rxt1_reg, rxt2_reg, rxt3_reg, txd1_reg, txd2_reg, txd3_reg} <= 6'h00;
    end else begin
      sel_m_reg <= boot_select;
      sel_s_reg <= sel_m_reg;
      miso_m_reg <= flash_data_in;
      miso_s_reg <= miso_m_reg;
      rxt1_reg <= uart_bus.rx_toggle;
      rxt2_reg <= rxt1_reg;
      rxt3_reg <= rxt2_reg;
      txd1_reg <= uart_bus.tx_done_toggle;
      txd2_reg <= txd1_reg;
      txd3_reg <= txd2_reg;
    end
  end

  // Received byte holding flag; a new byte wins over the take
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pend_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      rx_pend_reg <= rx_evt | (rx_pend_reg & ~rx_take);
      overrun_reg <= overrun_reg | (rx_evt & rx_pend_reg & ~rx_take);
    end
  end

  // Byte engine: clock idles high, data changes on fall, sampled after rise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_reg <= 1'b1;
      mosi_reg <= 1'b1;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      sh_reg <= '0;
      bit_reg <= '0;
      half_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (eng_go) begin
        busy_reg <= 1'b1;
        sh_reg <= tx_sel;
        sck_reg <= 1'b0;
        mosi_reg <= tx_sel[7];
        bit_reg <= '0;
        half_reg <= '0;
      end else if (busy_reg) begin
        half_reg <= half_end ? '0 : half_reg + 1'b1;
        if (half_end && !sck_reg) begin
          sck_reg <= 1'b1;
        end else if (half_end) begin
          sh_reg <= {sh_reg[6:0], miso_s_reg};
          bit_reg <= bit_reg + 1'b1;
          if (bit_reg == 3'h7) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end else begin
            sck_reg <= 1'b0;
            mosi_reg <= sh_reg[6];
          end
        end
      end
    end
  end

  // Two-entry output buffer; the engine stalls while it is full
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= '0;
      tail_reg <= '0;
    end else if (buf_pop) begin
      head_reg <= tail_v_reg ? tail_reg : {sec_sel, eng_rx};
      head_v_reg <= tail_v_reg | buf_push;
      tail_reg <= {sec_sel, eng_rx};
      tail_v_reg <= tail_v_reg & buf_push;
    end else if (buf_push && !head_v_reg) begin
      head_reg <= {sec_sel, eng_rx};
      head_v_reg <= 1'b1;
    end else if (buf_push) begin
      tail_reg <= {sec_sel, eng_rx};
      tail_v_reg <= 1'b1;
    end
  end

  // Command sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= st_strap;
      nxt_reg <= st_strap;
      ret_reg <= st_strap;
      strap_cnt_reg <= '0;
      mode_reg <= BOOT_SEL_FLASH;
      cs_b_reg <= 1'b1;
      sent_reg <= 1'b0;
      echo_sent_reg <= 1'b0;
      gap_reg <= '0;
      idx_reg <= '0;
      {cnt_reg, addr_reg, remain_reg, id_reg} <= '0;
      data_reg <= '0;
      erased_reg <= 1'b0;
      pp_open_reg <= 1'b0;
      tx_tog_reg <= 1'b0;
      tx_byte_reg <= '0;
    end else begin
      if (eng_go) begin
        sent_reg <= 1'b1;
        cs_b_reg <= 1'b0;
      end
      if (eng_done) sent_reg <= 1'b0;
      unique case (state_reg)
        st_strap: begin
          strap_cnt_reg <= strap_cnt_reg + 1'b1;
          if (strap_cnt_reg == 2'(STRAP_WAIT)) begin
            mode_reg <= sel_s_reg;
            state_reg <= (sel_s_reg == BOOT_SEL_UART) ? st_len : st_id_cmd;
          end
        end
        st_id_cmd: if (eng_done) state_reg <= st_id_data;
        st_id_data: if (eng_done) begin
          id_reg <= {id_reg[15:0], eng_rx};
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == 2'(ID_BYTES - 1)) begin
            idx_reg <= '0;
            cs_b_reg <= 1'b1;
            nxt_reg <= st_rd_cmd;
            state_reg <= st_gap;
          end
        end
        st_rd_cmd: if (eng_done) begin
          idx_reg <= last_hdr ? 2'h0 : idx_reg + 1'b1;
          if (last_hdr) state_reg <= st_rd_data;
        end
        st_rd_data: if (eng_done) begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == IMAGE_LAST) begin
            cs_b_reg <= 1'b1;
            nxt_reg <= st_boot_done;
            state_reg <= st_gap;
          end
        end
        st_boot_done: state_reg <= st_boot_done;
        st_len: if (rx_take) begin
          remain_reg <= {remain_reg[15:0], rx_data};
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == 2'(LEN_BYTES - 1)) begin
            idx_reg <= '0;
            state_reg <= st_wait_rx;
          end
        end
        st_wait_rx: begin
          if (remain_reg == '0) begin
            state_reg <= st_load_done;
          end else if (rx_take) begin
            data_reg <= rx_data;
            state_reg <= pp_open_reg ? st_pp_data : st_wren;
          end
        end
        st_wren: if (eng_done) begin
          cs_b_reg <= 1'b1;
          nxt_reg <= (sector_start && !erased_reg) ? st_erase : st_pp_hdr;
          state_reg <= st_gap;
        end
        st_erase: if (eng_done) begin
          idx_reg <= last_hdr ? 2'h0 : idx_reg + 1'b1;
          if (last_hdr) begin
            erased_reg <= 1'b1;
            cs_b_reg <= 1'b1;
            ret_reg <= st_wren;
            nxt_reg <= st_poll_cmd;
            state_reg <= st_gap;
          end
        end
        st_pp_hdr: if (eng_done) begin
          idx_reg <= last_hdr ? 2'h0 : idx_reg + 1'b1;
          if (last_hdr) begin
            pp_open_reg <= 1'b1;
            state_reg <= st_pp_data;
          end
        end
        st_pp_data: if (eng_done) begin
          addr_reg <= addr_reg + 1'b1;
          remain_reg <= remain_reg - 1'b1;
          if (sector_last) erased_reg <= 1'b0;
          if (page_last || remain_reg == 24'h000001) begin
            pp_open_reg <= 1'b0;
            cs_b_reg <= 1'b1;
            ret_reg <= st_echo;
            nxt_reg <= st_poll_cmd;
            state_reg <= st_gap;
          end else begin
            state_reg <= st_echo;
          end
        end
        st_poll_cmd: if (eng_done) state_reg <= st_poll_data;
        st_poll_data: if (eng_done) begin
          cs_b_reg <= 1'b1;
          nxt_reg <= eng_rx[STATUS_WIP_BIT] ? st_poll_cmd : ret_reg;
          state_reg <= st_gap;
        end
        st_echo: begin
          if (!echo_sent_reg) begin
            tx_byte_reg <= data_reg;
            tx_tog_reg <= ~tx_tog_reg;
            echo_sent_reg <= 1'b1;
          end else if (tx_done_evt) begin
            echo_sent_reg <= 1'b0;
            state_reg <= st_wait_rx;
          end
        end
        st_load_done: if (eng_done) begin
          cs_b_reg <= 1'b1;
          nxt_reg <= st_boot_done;
          state_reg <= st_gap;
        end
        st_gap: begin
          gap_reg <= gap_reg + 1'b1;
          if (gap_reg == HALF_LAST) begin
            gap_reg <= '0;
            state_reg <= nxt_reg;
          end
        end
      endcase
    end
  end
endmodule

// [tb/boot_loader_properties.sv]
// Port assertions for the boot loader
`timescale 1ns/1ps
module boot_loader_properties
  import boot_loader_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic boot_select,
  input wire logic flash_cs_b,
  input wire logic flash_serial_clock,
  input wire logic flash_data_out,
  input wire logic [7:0] image_data,
  input wire section_t image_section,
  input wire logic image_valid,
  input wire logic image_ready,
  input wire logic flash_boot_mode,
  input wire logic boot_done
);
  logic [2:0] cyc_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cyc_reg <= 3'h0;
    else if (cyc_reg != 3'h7) cyc_reg <= cyc_reg + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_sck_idle_high:
    assert property (flash_cs_b |-> flash_serial_clock) else $error("clock low while idle");
  a_mosi_on_fall:
    assert property (!flash_cs_b && $changed(flash_data_out) |-> $fell(flash_serial_clock)) else $error("data moved");
  a_sck_low_time:
    assert property ($fell(flash_serial_clock) |-> !flash_serial_clock [*3] ##1 flash_serial_clock) else $error("low");
  a_sck_high_min:
    assert property ($rose(flash_serial_clock) |-> flash_serial_clock [*3]) else $error("high too short");
  a_cs_gap_min:
    assert property ($rose(flash_cs_b) |-> flash_cs_b [*3]) else $error("select gap too short");
  a_cs_opens_clock:
    assert property ($fell(flash_cs_b) |-> $fell(flash_serial_clock)) else $error("frame start");
  a_strap_held:
    assert property (cyc_reg >= 3'h6 |-> $stable(flash_boot_mode)) else $error("boot mode moved");
  a_mode_from_strap:
    assert property (cyc_reg == 3'h6 |-> flash_boot_mode == (boot_select == BOOT_SEL_FLASH)) else $error("mode");
  a_stream_hold:
    assert property (image_valid && !image_ready |=> image_valid && $stable({image_data, image_section}))
      else $error("stream dropped");
  cover property (image_valid && image_ready);
  cover property (boot_done && flash_boot_mode);
  cover property (boot_done && !flash_boot_mode);
endmodule
bind boot_flash_uart_loader boot_loader_properties boot_loader_properties_inst (.clk(clk), .rst_b(rst_b),
  .boot_select(boot_select), .flash_cs_b(flash_cs_b), .flash_serial_clock(flash_serial_clock),
  .flash_data_out(flash_data_out), .image_data(image_data), .image_section(image_section),
  .image_valid(image_valid), .image_ready(image_ready), .flash_boot_mode(flash_boot_mode), .boot_done(boot_done));

// [tb/flash_model.sv]
// Behavioural serial flash for identification, read and status commands
`timescale 1ns/1ps
module flash_model
  import boot_loader_pkg::*;
#(
  parameter logic [23:0] ID_CODE = 24'h3c5a96 // Arbitrary value
) (
  input wire logic cs_b,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] last_op
);
  int n = 0;
  logic [7:0] sh = 8'h00;
  logic [23:0] addr = 24'h0;
  logic [7:0] resp;
  initial miso = 1'b0;
  initial last_op = 8'h00;
  // Frame ends: released line shows the inverse of its last bit
  always @(posedge cs_b) begin
    n = 0;
    miso = ~miso;
  end
  always @(posedge sck) if (!cs_b) begin
    sh = {sh[6:0], mosi};
    n++;
    if (n == 8) last_op = sh;
    else if (n <= 32 && n % 8 == 0) addr = {addr[15:0], sh};
  end
  function automatic logic [7:0] answer(input int k);
    if (last_op == CMD_READ_ID && k >= 1 && k <= 3) return ID_CODE[8 * (3 - k) +: 8];
    if (last_op == CMD_READ_STATUS) return 8'h00;
    if (last_op == CMD_READ_DATA && k >= 4) return 8'ha5 ^ 8'(addr + 24'(k - 4));
    return 8'hff;
  endfunction
  always @(negedge sck or negedge cs_b) if (!cs_b) begin
    resp = answer(n / 8);
    miso = resp[7 - n % 8];
  end
endmodule

// [tb/boot_flash_uart_loader_bench.sv]
// Self-checking bench for the boot loader
`timescale 1ns/1ps
module boot_flash_uart_loader_bench
  import boot_loader_pkg::*;
;
  localparam int IMG = 32;
  localparam int CFG = 4;
  localparam logic [23:0] ID = 24'h3c5a96;
  typedef struct {int last; section_t sec;} row_s;
  row_s rows[3] = '{'{17, SEC_NET_ADDR}, '{17 + CFG, SEC_CONFIG}, '{IMG - 1, SEC_FIRMWARE}};
  logic clk, uart_clk, rst_b, boot_select, rx, tx, cs_b, sck, mosi, miso, image_valid, image_ready;
  logic [7:0] image_data, last_op;
  section_t image_section;
  logic [23:0] flash_id;
  logic flash_boot_mode, boot_done, uart_overrun;
  logic [7:0] echo;
  logic [55:0] ops = '0;
  int num_errors = 0;
  int checked = 0;
  int i;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    uart_clk = 1'b0;
    #37;
    forever #80 uart_clk = ~uart_clk;
  end
  boot_flash_uart_loader #(.IMAGE_BYTES(IMG), .CONFIG_BYTES(CFG)) boot_flash_uart_loader_inst (.clk(clk),
    .rst_b(rst_b), .uart_clk(uart_clk), .boot_select(boot_select), .boot_serial_rx_line(rx),
    .boot_serial_tx_line(tx), .flash_cs_b(cs_b), .flash_serial_clock(sck), .flash_data_out(mosi),
    .flash_data_in(miso), .image_data(image_data), .image_section(image_section), .image_valid(image_valid),
    .image_ready(image_ready), .flash_id(flash_id), .flash_boot_mode(flash_boot_mode), .boot_done(boot_done),
    .uart_overrun(uart_overrun));
  flash_model #(.ID_CODE(ID)) flash_model_inst (.cs_b(cs_b), .sck(sck), .mosi(mosi), .miso(miso),
    .last_op(last_op));
  // Opcodes of the last seven finished flash frames, newest in the low byte
  always @(posedge cs_b) ops = {ops[47:0], last_op};
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_hi(input int sel, input int lim);
    int k;
    for (k = 0; k < lim && !(sel ? boot_done : image_valid); k++) @(negedge clk);
    if ((sel ? boot_done : image_valid) !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask
  task automatic pop(input logic [7:0] ed, input section_t es);
    wait_hi(0, 2000);
    chk(image_data, ed);
    chk(image_section, es);
    image_ready = 1'b1;
    @(negedge clk);
    image_ready = 1'b0;
  endtask
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(negedge uart_clk);
    for (int j = 0; j < 10; j++) begin
      rx = f[j];
      repeat (54) @(negedge uart_clk);
    end
  endtask
  task automatic uart_recv(output logic [7:0] b);
    int k;
    b = 8'h00;
    for (k = 0; k < 4000 && tx !== 1'b0; k++) @(negedge uart_clk);
    if (tx !== 1'b0) begin
      num_errors++;
      $display("[ERR] %0t echo never started", $time);
      final_report();
    end
    repeat (27) @(negedge uart_clk);
    for (int j = 0; j < 8; j++) begin
      repeat (54) @(negedge uart_clk);
      b[j] = tx;
    end
  endtask
  initial begin
    rst_b = 1'b0;
    boot_select = BOOT_SEL_FLASH;
    rx = 1'b1;
    image_ready = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
    boot_select = BOOT_SEL_UART;
    wait_hi(0, 2000);
    // Flash read engine stalls while the buffer is full
    repeat (300) @(negedge clk);
    i = 0;
    foreach (rows[r]) begin
      while (i <= rows[r].last) begin
        pop(8'ha5 ^ 8'(i), rows[r].sec);
        i++;
      end
    end
    wait_hi(1, 2000);
    chk(flash_id, ID);
    chk(flash_boot_mode, 1'b1);
    chk(last_op, CMD_READ_DATA);
    $display("flash boot test done");
    rst_b = 1'b0;
    @(negedge clk);
    chk({cs_b, sck, image_valid, boot_done, flash_id}, {4'hc, 24'h0});
    repeat (15) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    for (i = 0; i < 3; i++) uart_send(8'h00);
    wait_hi(1, 3000);
    chk(flash_boot_mode, 1'b0);
    chk(last_op, CMD_WRITE_DISABLE);
    chk(image_valid, 1'b0);
    $display("uart load test done");
    // One byte load: erase, program, status polls and echo
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    uart_send(8'h00);
    uart_send(8'h00);
    uart_send(8'h01);
    uart_send(8'h5c);
    uart_recv(echo);
    chk(echo, 8'h5c);
    wait_hi(1, 3000);
    chk(ops[55:32], {CMD_WRITE_ENABLE, SECTOR_ERASE_CMD, CMD_READ_STATUS});
    chk(ops[31:0], {CMD_WRITE_ENABLE, CMD_PAGE_PROGRAM, CMD_READ_STATUS, CMD_WRITE_DISABLE});
    chk(uart_overrun, 1'b0);
    chk(tx, 1'b1);
    $display("uart program test done");
    final_report();
  end
endmodule
